// file: core/cmpdc_regs.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMPDC_REGS_SVH
`define CMPDC_REGS_SVH
`define CMPDC_CTRL0_OFS    12'h000
`define CMPDC_CTRL1_OFS    12'h004
`define CMPDC_MIRROR_OFS   12'h008
`define CMPDC_FLAGS_OFS    12'h00C
`define CMPDC_IRQEN_OFS    12'h010
`define CMPDC_DIR_OFS      12'h014
`define CMPDC_CTRL0_RST    8'h00
`define CMPDC_CTRL1_RST    8'h00
`define CMPDC_DIR_RST      1'h1
`define CMPDC_IRQEN_RST    3'h0
`define CMPDC_UNUSED       3
`define CMPDC_C0_ON        7
`define CMPDC_C0_RES       6
`define CMPDC_C0_PIN       5
`define CMPDC_C0_INV       4
`define CMPDC_C0_SPD       2
`define CMPDC_C0_HYS       1
`define CMPDC_C0_SYNC      0
`define CMPDC_C1_RISE      7
`define CMPDC_C1_FALL      6
`define CMPDC_C1_PLUS_HI   5
`define CMPDC_C1_PLUS_LO   4
`define CMPDC_C1_MINUS_HI  2
`define CMPDC_C1_MINUS_LO  0
`define CMPDC_IE_EDGE      0
`define CMPDC_IE_PERIPH    1
`define CMPDC_IE_GLOBAL    2
`endif

// file: core/cmpdc_pkg.sv
// types of the comparator control block
`default_nettype none
package cmpdc_pkg;
  typedef logic [1:0] cmpdc_plus_sel_t;
  typedef logic [2:0] cmpdc_minus_sel_t;
  typedef enum logic [1:0] {PLUS_PIN, PLUS_DAC, PLUS_FIXED_REF, PLUS_GROUND} cmpdc_plus_src_t;
  typedef enum logic [2:0] {MINUS_PIN0, MINUS_PIN1, MINUS_RSV2, MINUS_RSV3,
                            MINUS_RSV4, MINUS_RSV5, MINUS_FIXED_REF, MINUS_GROUND} cmpdc_minus_src_t;
endpackage
`default_nettype wire

// file: core/cmpdc_top.sv
// comparator digital control: registers, result path, edge flag and timer sync
// Summary of operation
// - hysteresis on only while control bit set
// - sync mode captures result on timer fall
// - capture clocked by prescaler output clock
// - sync clear passes result untimed
// - timer counts on rising edge only
// - result offered as timer gate source
// - rising result edge sets flag if enabled
// - falling result edge sets flag if enabled
// - both detectors feed one event flag
// - interrupt needs all three enables
// - flag cleared by software; set wins
// - polarity or enable toggles still flag
// - result is comparison xor invert bit
// - pin driven by pin bit and direction, not by enable
// - enable bit powers the comparator
// - speed bit picks fast or low power
// - plus input select two-bit mapping
// - minus input select three-bit mapping
// - mirror register holds result lsb
// - unused bits read zero
// - internal result resampled each cycle
// - timed result to adc, untimed to generator
`timescale 1ns/1ps
`default_nettype none
`include "cmpdc_regs.svh"

module cmpdc_top
  import cmpdc_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     raw_compare,
  input  wire logic                     timer_count_clk,
  output logic                          comparator_on,
  output logic                          speed_select,
  output logic                          hysteresis_on,
  output cmpdc_pkg::cmpdc_plus_sel_t    plus_input_select,
  output cmpdc_pkg::cmpdc_minus_sel_t   minus_input_select,
  output logic                          timed_result,
  output logic                          untimed_result,
  output logic                          timer_gate,
  output logic                          result_pin_out,
  output logic                          result_pin_oe_n,
  output logic                          irq
);
  import cmpdc_pkg::*;

  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [2:0] irq_en_r;
  logic       pin_direction_r;
  logic       edge_event_flag_r;
  logic [1:0] raw_sync_r;
  logic [1:0] tclk_sync_r;
  logic       tclk_prev_r;
  logic       comparator_result_r;
  logic       result_prev_r;
  logic       sync_latch_r;
  logic       pready_r;

  logic wr_acc;
  logic rd_acc;
  logic comp_now;
  logic timer_fall;
  logic rise_evt;
  logic fall_evt;
  logic set_evt;
  logic clr_evt;
  logic out_sel;
  logic [7:0] rd_byte;
  logic       addr_ok;

  assign wr_acc = clk_en && psel && penable && pwrite && pready_r;
  assign rd_acc = clk_en && psel && penable && !pwrite && pready_r;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `CMPDC_CTRL0_OFS:  rd_byte = {ctrl0_r[7], comparator_result_r, ctrl0_r[5:4], 1'b0, ctrl0_r[2:0]};
      `CMPDC_CTRL1_OFS:  rd_byte = {ctrl1_r[7:4], 1'b0, ctrl1_r[2:0]};
      `CMPDC_MIRROR_OFS: rd_byte = {7'h00, comparator_result_r};
      `CMPDC_FLAGS_OFS:  rd_byte = {7'h00, edge_event_flag_r};
      `CMPDC_IRQEN_OFS:  rd_byte = {5'h00, irq_en_r};
      `CMPDC_DIR_OFS:    rd_byte = {7'h00, pin_direction_r};
      default:           addr_ok = 1'b0;
    endcase
  end

  // checked where the read completes, with prdata standing
  a_mirror_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `CMPDC_MIRROR_OFS |-> prdata[31:1] == 31'h0000_0000)
    else $error("mirror upper bits not zero");

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end
    else if (clk_en)
    begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= !addr_ok;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end
  assign pready = pready_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_r         <= `CMPDC_CTRL0_RST;
      ctrl1_r         <= `CMPDC_CTRL1_RST;
      irq_en_r        <= `CMPDC_IRQEN_RST;
      pin_direction_r <= `CMPDC_DIR_RST;
    end
    else if (wr_acc && pstrb[0])
    begin
      case (paddr)
        `CMPDC_CTRL0_OFS: ctrl0_r  <= {pwdata[7], 1'b0, pwdata[5:4], 1'b0, pwdata[2:0]};
        `CMPDC_CTRL1_OFS: ctrl1_r  <= {pwdata[7:4], 1'b0, pwdata[2:0]};
        `CMPDC_IRQEN_OFS: irq_en_r <= pwdata[2:0];
        `CMPDC_DIR_OFS:   pin_direction_r <= pwdata[0];
        default:          ;
      endcase
    end
  end

  // unused positions are never stored, so reads cannot expose them
  a_unused_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl0_r[`CMPDC_C0_RES] && !ctrl0_r[`CMPDC_UNUSED] && !ctrl1_r[`CMPDC_UNUSED])
    else $error("unused control bit set");

  // two-stage synchroniser for the analog result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      raw_sync_r <= 2'b00;
    else if (clk_en)
      raw_sync_r <= {raw_sync_r[0], raw_compare};
  end

  // timer clock input is already the prescaled clock; synchronised here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tclk_sync_r <= 2'b00;
      tclk_prev_r <= 1'b0;
    end
    else if (clk_en)
    begin
      tclk_sync_r <= {tclk_sync_r[0], timer_count_clk};
      tclk_prev_r <= tclk_sync_r[1];
    end
  end
  assign timer_fall = tclk_prev_r && !tclk_sync_r[1];

  // polarity; disabled comparator still yields an inverted level
  // off comparator output reads low before inversion
  assign comp_now = (ctrl0_r[`CMPDC_C0_ON] & raw_sync_r[1]) ^ ctrl0_r[`CMPDC_C0_INV];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comparator_result_r <= 1'b0;
      result_prev_r       <= 1'b0;
    end
    else if (clk_en)
    begin
      comparator_result_r <= comp_now;
      result_prev_r       <= comparator_result_r;
    end
  end

  // capture on timer clock fall; timer counts on the rise, so no race
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_latch_r <= 1'b0;
    else if (clk_en && timer_fall)
      sync_latch_r <= comparator_result_r;
  end

  // the latch reads the resampled result, so the timer never races it
  a_sync_capture: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && timer_fall |=> sync_latch_r == $past(comparator_result_r))
    else $error("sync latch missed a timer fall");
  a_timed_from_latch: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl0_r[`CMPDC_C0_SYNC] |=> timed_result == $past(sync_latch_r))
    else $error("timed result not from latch");

  assign out_sel = ctrl0_r[`CMPDC_C0_SYNC] ? sync_latch_r : comparator_result_r;

  assign rise_evt = ctrl1_r[`CMPDC_C1_RISE] && comparator_result_r && !result_prev_r;
  assign fall_evt = ctrl1_r[`CMPDC_C1_FALL] && !comparator_result_r && result_prev_r;
  assign set_evt  = rise_evt || fall_evt;
  // writing 0 clears; writing 1 is harmless, so stray writes keep the flag
  assign clr_evt  = wr_acc && pstrb[0] && (paddr == `CMPDC_FLAGS_OFS) && !pwdata[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      edge_event_flag_r <= 1'b0;
    else if (clk_en)
    begin
      if (set_evt)
        edge_event_flag_r <= 1'b1;
      else if (clr_evt)
        edge_event_flag_r <= 1'b0;
    end
  end

  a_clear_takes: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && clr_evt && !set_evt |=> !edge_event_flag_r)
    else $error("flag not cleared by write");
  // a stalled instruction cycle must leave every flop alone
  a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(ctrl0_r) && $stable(edge_event_flag_r) && $stable(comparator_result_r) && $stable(pready))
    else $error("state moved while frozen");
  a_rise_masked: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !edge_event_flag_r && !ctrl1_r[`CMPDC_C1_RISE] && !fall_evt |=> !edge_event_flag_r)
    else $error("masked rise set flag");
  a_fall_masked: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !edge_event_flag_r && !ctrl1_r[`CMPDC_C1_FALL] && !rise_evt |=> !edge_event_flag_r)
    else $error("masked fall set flag");
  a_result_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ctrl0_r[`CMPDC_C0_ON] |=> comparator_result_r == $past(ctrl0_r[`CMPDC_C0_INV]))
    else $error("off result not polarity level");

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comparator_on      <= 1'b0;
      speed_select       <= 1'b0;
      hysteresis_on      <= 1'b0;
      plus_input_select  <= 2'b00;
      minus_input_select <= 3'b000;
      timed_result       <= 1'b0;
      untimed_result     <= 1'b0;
      timer_gate         <= 1'b0;
      result_pin_out     <= 1'b0;
      result_pin_oe_n    <= 1'b1;
      irq                <= 1'b0;
    end
    else if (clk_en)
    begin
      comparator_on      <= ctrl0_r[`CMPDC_C0_ON];
      speed_select       <= ctrl0_r[`CMPDC_C0_SPD];
      hysteresis_on      <= ctrl0_r[`CMPDC_C0_HYS];
      // plus select mapping passed to analog core
      plus_input_select  <= ctrl1_r[`CMPDC_C1_PLUS_HI:`CMPDC_C1_PLUS_LO];
      // minus select, reserved codes passed unchanged
      minus_input_select <= ctrl1_r[`CMPDC_C1_MINUS_HI:`CMPDC_C1_MINUS_LO];
      // timed to adc and timer, untimed to generator
      timed_result       <= out_sel;
      untimed_result     <= comparator_result_r;
      timer_gate         <= out_sel;
      result_pin_out     <= out_sel;
      result_pin_oe_n    <= !(ctrl0_r[`CMPDC_C0_PIN] && !pin_direction_r);
      irq                <= edge_event_flag_r && (&irq_en_r);
    end
  end

  // each output trails its control bit or source by one edge
  a_enable_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> comparator_on == $past(ctrl0_r[`CMPDC_C0_ON]))
    else $error("enable output not following bit");
  a_speed_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> speed_select == $past(ctrl0_r[`CMPDC_C0_SPD]))
    else $error("speed output not following bit");
  a_plus_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> plus_input_select == $past(ctrl1_r[`CMPDC_C1_PLUS_HI:`CMPDC_C1_PLUS_LO]))
    else $error("plus select not following field");
  a_minus_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> minus_input_select == $past(ctrl1_r[`CMPDC_C1_MINUS_HI:`CMPDC_C1_MINUS_LO]))
    else $error("minus select not following field");
  a_untimed_path: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> untimed_result == $past(comparator_result_r))
    else $error("untimed result re-timed");
  a_gate_pin_same: assert property (@(posedge pclk) disable iff (!presetn)
    timer_gate == timed_result && result_pin_out == timed_result)
    else $error("gate or pin differs from timed result");
  a_pin_drive_on: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl0_r[`CMPDC_C0_PIN] && !pin_direction_r |=> !result_pin_oe_n)
    else $error("pin not driven when selected");
  a_irq_all_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && edge_event_flag_r && (&irq_en_r) |=> irq)
    else $error("irq missing with all enables");
  a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !edge_event_flag_r |=> !irq)
    else $error("irq without flag");

  a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && set_evt |=> edge_event_flag_r)
    else $error("edge flag lost on set");
  a_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl1_r[7] && comparator_result_r && !result_prev_r |=> edge_event_flag_r)
    else $error("rise did not set flag");
  a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl1_r[6] && !comparator_result_r && result_prev_r |=> edge_event_flag_r)
    else $error("fall did not set flag");
  a_no_edge_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !set_evt && !clr_evt |=> edge_event_flag_r == $past(edge_event_flag_r))
    else $error("flag changed without cause");
  a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !(&irq_en_r) |=> !irq)
    else $error("irq without all enables");
  a_pin_direction: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && pin_direction_r |=> result_pin_oe_n)
    else $error("pin driven while input");
  a_sync_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ctrl0_r[0] |=> timed_result == $past(comparator_result_r))
    else $error("bypass result wrong");
  a_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctrl0_r[0] && !timer_fall |=> sync_latch_r == $past(sync_latch_r))
    else $error("sync latch moved off fall");
  a_polarity_map: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> comparator_result_r == $past(comp_now))
    else $error("result not polarity adjusted");
  a_hys_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en ##1 clk_en |-> hysteresis_on == $past(ctrl0_r[1]))
    else $error("hysteresis not following bit");

  c_rise_event: cover property (@(posedge pclk) disable iff (!presetn) rise_evt);
  c_fall_event: cover property (@(posedge pclk) disable iff (!presetn) fall_evt);
  c_set_and_clr: cover property (@(posedge pclk) disable iff (!presetn) set_evt && clr_evt);
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_sync_capture: cover property (@(posedge pclk) disable iff (!presetn) clk_en && timer_fall && ctrl0_r[0]);

endmodule // cmpdc_top
`default_nettype wire

// file: bench/cmpdc_partner.sv
// analog comparison source and timer count clock of the far side
`timescale 1ns/1ps
`default_nettype none
module cmpdc_partner
(
  input  wire logic clk_run,
  input  wire logic level,
  output logic      raw_compare,
  output logic      timer_count_clk
);
  initial timer_count_clk = 1'b0;
  // prescaled clock, stands still when idle
  always #41 if (clk_run) timer_count_clk = ~timer_count_clk;
  assign raw_compare = level;
endmodule // cmpdc_partner
`default_nettype wire

// file: bench/test_cmpdc_top.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "cmpdc_regs.svh"
module test_cmpdc_top;
  import cmpdc_pkg::*;
  localparam logic [11:0] C0 = `CMPDC_CTRL0_OFS;
  localparam logic [11:0] C1 = `CMPDC_CTRL1_OFS;
  localparam logic [11:0] MR = `CMPDC_MIRROR_OFS;
  localparam logic [11:0] FL = `CMPDC_FLAGS_OFS;
  localparam logic [11:0] IE = `CMPDC_IRQEN_OFS;
  localparam logic [11:0] DR = `CMPDC_DIR_OFS;
  logic             pclk, presetn, psel, penable, pwrite, level, run, wiggle, e, ce;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [3:0]       pstrb;
  logic             pready, pslverr, raw_compare, timer_count_clk, comparator_on, speed_select, hysteresis_on;
  logic             timed_result, untimed_result, timer_gate, result_pin_out, result_pin_oe_n, irq;
  cmpdc_plus_sel_t  plus_input_select;
  cmpdc_minus_sel_t minus_input_select;
  int               miscompares, checked, cycles;

  cmpdc_top cmpdc_top_i (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .raw_compare, .timer_count_clk, .comparator_on, .speed_select, .hysteresis_on,
    .plus_input_select, .minus_input_select, .timed_result, .untimed_result, .timer_gate, .result_pin_out,
    .result_pin_oe_n, .irq);
  cmpdc_partner cmpdc_partner_i (.clk_run(run), .level, .raw_compare, .timer_count_clk);

  always #4 pclk = ~pclk;
  // toggles every cycle so an edge meets the clearing write
  always @(posedge pclk) if (wiggle) level <= ~level;

  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h1);
    chk(nm, q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_reset();
    rdc("ctrl0", C0, 32'h0);
    rdc("ctrl1", C1, 32'h0);
    rdc("mirror", MR, 32'h0);
    rdc("dir", DR, 32'h1);
    chk("oe_n", result_pin_oe_n, 1'b1);
  endtask

  task automatic t_ctrl();
    wr(C0, 32'hFF);
    cyc(6);
    rdc("ctrl0_all", C0, 32'hF7);
    chk("on", comparator_on, 1'b1);
    chk("speed", speed_select, 1'b1);
    chk("hys", hysteresis_on, 1'b1);
    wr(C0, 32'h0);
    cyc(1);
    chk("ctl_off", {comparator_on, speed_select, hysteresis_on}, 3'h0);
    for (int i = 0; i < 32; i++)
    begin
      wr(C1, {26'h0, i[4:3], 1'b1, i[2:0]});
      cyc(1);
      chk("plus", plus_input_select, i[4:3]);
      chk("minus", minus_input_select, i[2:0]);
      rdc("ctrl1", C1, {26'h0, i[4:3], 1'b0, i[2:0]});
    end
    wr(C1, 32'h0);
  endtask

  task automatic t_result();
    wr(C0, 32'h80);
    level <= 1'b1;
    cyc(6);
    chk("untimed", untimed_result, 1'b1);
    chk("timed", timed_result, 1'b1);
    chk("gate", timer_gate, 1'b1);
    rdc("mirror1", MR, 32'h1);
    wr(C0, 32'h90);
    cyc(4);
    rdc("inv_hi", C0, 32'h90);
    level <= 1'b0;
    cyc(6);
    rdc("inv_lo", C0, 32'hD0);
  endtask

  task automatic t_pin();
    wr(C0, 32'h30);
    cyc(4);
    chk("oe_dir_in", result_pin_oe_n, 1'b1);
    wr(DR, 32'h0);
    cyc(2);
    chk("oe_dir_out", result_pin_oe_n, 1'b0);
    chk("pin_no_on", result_pin_out, 1'b1);
    wr(C0, 32'h0);
    cyc(4);
    chk("pin_off", {result_pin_oe_n, result_pin_out}, 2'h2);
    wr(DR, 32'h1);
  endtask

  task automatic t_edge();
    wr(C1, 32'h80);
    wr(FL, 32'h0);
    wr(C0, 32'h10);
    cyc(6);
    rdc("pol_rise", FL, 32'h1);
    wr(FL, 32'h1);
    rdc("w1_keeps", FL, 32'h1);
    wr(FL, 32'h0);
    wr(C0, 32'h0);
    cyc(6);
    rdc("fall_off", FL, 32'h0);
    wr(C1, 32'h40);
    wr(C0, 32'h80);
    level <= 1'b1;
    cyc(6);
    rdc("rise_off", FL, 32'h0);
    level <= 1'b0;
    cyc(6);
    rdc("fall_on", FL, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(IE, 32'(i));
      cyc(2);
      chk("irq_mask", irq, i == 7);
    end
    wr(C1, 32'hC0);
    wiggle <= 1'b1;
    wr(FL, 32'h0);
    rdc("clr_race", FL, 32'h1);
    wiggle <= 1'b0;
    cyc(6);
    wr(FL, 32'h0);
    rdc("cleared", FL, 32'h0);
    chk("irq_clr", irq, 1'b0);
  endtask

  task automatic t_sync();
    wr(C1, 32'h0);
    level <= 1'b0;
    // sync chosen before the result gates the timer
    wr(C0, 32'h81);
    level <= 1'b1;
    cyc(6);
    chk("untimed", untimed_result, 1'b1);
    chk("held", {timed_result, timer_gate}, 2'h0);
    run <= 1'b1;
    @(negedge timer_count_clk);
    run <= 1'b0;
    cyc(6);
    chk("captured", {timed_result, timer_gate, result_pin_out}, 3'h7);
    level <= 1'b0;
    cyc(6);
    chk("still", timed_result, 1'b1);
    chk("untimed0", untimed_result, 1'b0);
    wr(C0, 32'h80);
    cyc(4);
    chk("async", timed_result, 1'b0);
  endtask

  task automatic t_refuse();
    apb(1'b0, 12'h020, 32'h0, 4'h1);
    chk("slverr", e, 1'b1);
    wr(MR, 32'hFF);
    rdc("mirror_ro", MR, 32'h0);
    apb(1'b1, C0, 32'hFF, 4'h0);
    rdc("no_strb", C0, 32'h80);
  endtask

  // low enable must hold the result pipeline still
  task automatic t_freeze();
    ce <= 1'b0;
    level <= 1'b1;
    cyc(8);
    chk("frozen", untimed_result, 1'b0);
    ce <= 1'b1;
    cyc(6);
    chk("thawed", untimed_result, 1'b1);
  endtask

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, level, run, wiggle} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h1;
    {miscompares, checked, cycles} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ctrl();
    t_result();
    t_pin();
    t_edge();
    t_sync();
    t_refuse();
    t_freeze();
    report_and_stop();
  end
endmodule // test_cmpdc_top
`default_nettype wire
